// file: pkg/akt_pkg.sv
// Purpose: Shared constants and types for the audio keep-alive timestamp block
// Assumes: One clock hclk at 25 MHz; 32-bit AHB-Lite register words
// Notes: Offsets are byte addresses of the controller's own register window
package akt_pkg;
  // Clock figures
  localparam int CLK_MHZ = 25;
  localparam int MODE_WAIT_US = 100;
  localparam int MODE_WAIT_CYC = MODE_WAIT_US * CLK_MHZ;
  // Device register field layout
  localparam int TS_VAL_W = 24;
  localparam int TS_EN_BIT = 31;
  localparam int KA_BIT = 7;
  localparam int SYNTH_BIT = 0;
  // Device register indices over the link
  localparam logic [1:0] DEV_MULT = 2'h0;
  localparam logic [1:0] DEV_DIV = 2'h1;
  localparam logic [1:0] DEV_VERB = 2'h2;
  localparam logic [1:0] DEV_MISC = 2'h3;
  // Controller register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MULT = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0C;
  localparam logic [7:0] OFS_MISC = 8'h10;
  localparam logic [7:0] OFS_TS = 8'h14;
  // Command codes written to the command register
  localparam logic [2:0] CMD_MODE = 3'h1;
  localparam logic [2:0] CMD_CLK = 3'h2;
  localparam logic [2:0] CMD_WMISC = 3'h3;
  localparam logic [2:0] CMD_KA_ON = 3'h4;
  localparam logic [2:0] CMD_KA_OFF = 3'h5;
  localparam logic [31:0] SILENT_WORD = 32'h0000_0000;
endpackage : akt_pkg

// file: pkg/akt_link_if.sv
// Purpose: Carrier between the audio controller end and the codec end
// Assumes: Single clock, register writes are one-cycle strobes
// Notes: Frame data and configuration share one interface
`timescale 1ns/100ps
interface akt_link_if;
  // Register write port of the codec
  logic cfg_we;
  logic [1:0] cfg_idx;
  logic [31:0] cfg_wdata;
  // Stream from the controller
  logic frame_sync;
  logic [3:0] stream_id;
  logic [31:0] stream_data;
  logic bclk_on;
  // Codec state returned
  logic ka_active;
  logic [31:0] ts_value;
  modport codec (
    input cfg_we, cfg_idx, cfg_wdata, frame_sync, stream_id, stream_data, bclk_on,
    output ka_active, ts_value
  );
  modport ctrl (
    output cfg_we, cfg_idx, cfg_wdata, frame_sync, stream_id, stream_data, bclk_on,
    input ka_active, ts_value
  );
endinterface : akt_link_if

// file: logic/akt_ts_gen.sv
// Purpose: Fractional timestamp accumulator scaled by multiplier over divisor
// Assumes: Divisor nonzero when enabled; core clock not at reference rate
//   Multiplier not above divisor: at most one tick per clock
// Notes: Advances mult/div counts per clock, like a DDA
`timescale 1ns/100ps
module akt_ts_gen #(
  parameter int W = akt_pkg::TS_VAL_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [W-1:0] mult,
  input wire logic [W-1:0] div,
  // Result
  output logic [31:0] ts
);
  typedef struct packed {
    logic [W:0] acc;
    logic [31:0] ts;
  } akt_tsg_type;
  akt_tsg_type st_reg, st_next;
  logic [W:0] sum;

  // Accumulate multiplier, emit one tick per divisor wrap
  always_comb begin
    st_next = st_reg;
    sum = st_reg.acc + {1'b0, mult};
    if (run && div != '0) begin
      if (sum >= {1'b0, div}) begin
        st_next.acc = sum - {1'b0, div};
        st_next.ts = st_reg.ts + 32'h0000_0001;
      end else begin
        st_next.acc = sum;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ts = st_reg.ts;
endmodule // akt_ts_gen

// file: logic/akt_codec.sv
// Purpose: Codec end: keep-alive stream substitution and link-off timestamps
// Assumes: Inputs synchronous to hclk, which stands for the core display clock
// Notes: Timestamps run from hclk only while the bit clock is off
`timescale 1ns/100ps
module akt_codec (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link side
  akt_link_if.codec lnk,
  // Transport side
  output logic out_valid,
  output logic out_silent,
  output logic [31:0] out_data
);
  typedef struct packed {
    logic ka;
    logic synth;
    logic ts_en;
    logic [akt_pkg::TS_VAL_W-1:0] mult;
    logic [akt_pkg::TS_VAL_W-1:0] div;
    logic valid;
    logic silent;
    logic [31:0] data;
  } akt_cod_type;
  akt_cod_type st_reg, st_next;
  logic [31:0] ts;
  logic ka_on;

  assign ka_on = st_reg.ka && st_reg.synth;

  // Link-off timestamp generator
  akt_ts_gen #(.W(akt_pkg::TS_VAL_W)) u_ts (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ka_on && st_reg.ts_en && !lnk.bclk_on),
    .mult(st_reg.mult),
    .div(st_reg.div),
    .ts(ts)
  );

  // Register writes and per-frame stream choice
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    if (lnk.cfg_we) begin
      unique case (lnk.cfg_idx)
        akt_pkg::DEV_MULT: begin
          st_next.mult = lnk.cfg_wdata[akt_pkg::TS_VAL_W-1:0];
          st_next.ts_en = lnk.cfg_wdata[akt_pkg::TS_EN_BIT];
        end
        akt_pkg::DEV_DIV: st_next.div = lnk.cfg_wdata[akt_pkg::TS_VAL_W-1:0];
        akt_pkg::DEV_VERB: st_next.ka = lnk.cfg_wdata[akt_pkg::KA_BIT];
        akt_pkg::DEV_MISC: st_next.synth = lnk.cfg_wdata[akt_pkg::SYNTH_BIT];
      endcase
    end
    if (lnk.frame_sync || (ka_on && !lnk.bclk_on)) begin
      if (lnk.bclk_on && lnk.stream_id != 4'h0) begin
        st_next.valid = 1'b1;
        st_next.silent = 1'b0;
        st_next.data = lnk.stream_data;
      end else if (ka_on) begin
        st_next.valid = 1'b1;
        st_next.silent = 1'b1;
        st_next.data = akt_pkg::SILENT_WORD;
      end
    end
  end

  // State register, keep-alive cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid;
  assign out_silent = st_reg.silent;
  assign out_data = st_reg.data;
  assign lnk.ka_active = ka_on;
  assign lnk.ts_value = ts;
endmodule // akt_codec

// file: logic/akt_ctrl.sv
// Purpose: Controller end: AHB-Lite slave that sequences codec programming
// Assumes: Single word transfers, response always OKAY
// Notes: Commands run as timed step sequences; busy shows in status
//   A command is dropped unless the sequencer is in ST_IDLE the cycle after it lands, so software polls busy first
//   Read data stands from its address phase until the next read is taken
//
// Summary of operation
// - Keep-alive needs verb bit and synthesis enable
// - Valid stream forwarded, else silence sent
// - Keep-alive comes out of reset cleared
// - Link-off silence and timestamps from core clock
// - Reference-rate core clock timestamps unsupported
// - Mode change: clear, wait, change, wait, set
// - Clear timestamp enable before clock change
// - Divisor held in bits 23 to 0
// - Multiplier held in bits 23 to 0, after divisor
// - Set timestamp enable after both values written
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module akt_ctrl #(
  parameter int WAIT_CYC = akt_pkg::MODE_WAIT_CYC
) (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Stream source
  input wire logic src_frame_sync,
  input wire logic [3:0] src_stream_id,
  input wire logic [31:0] src_data,
  input wire logic src_bclk_on,
  // Codec link
  akt_link_if.ctrl lnk
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_KA_OFF = 3'b001,
    ST_WAIT1 = 3'b010,
    ST_WAIT2 = 3'b011,
    ST_KA_ON = 3'b100,
    ST_WDIV = 3'b101,
    ST_WMULT = 3'b110,
    ST_TSON = 3'b111
  } akt_state_type;

  typedef struct packed {
    akt_state_type state;
    logic [15:0] cnt;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic [2:0] cmd;
    logic clk_done;
    logic [akt_pkg::TS_VAL_W-1:0] mult;
    logic [akt_pkg::TS_VAL_W-1:0] div;
    logic misc;
    logic we;
    logic [1:0] idx;
    logic [31:0] wdata;
  } akt_ctl_type;
  akt_ctl_type st_reg, st_next;
  logic busy;

  // Busy also covers a command written but not yet picked up, so a status
  // poll whose address phase comes after the write's data phase never reads a false idle
  assign busy = st_reg.state != ST_IDLE || st_reg.cmd != 3'h0;

  // Bus decode, command sequencer and link writes
  always_comb begin
    st_next = st_reg;
    st_next.we = 1'b0;
    st_next.cmd = 3'h0;
    st_next.dph = hsel && hready && htrans[1];
    st_next.dwr = hwrite;
    st_next.daddr = haddr;
    // Read data captured at the address phase of a read only, so it holds
    // steady through the data phase while the master takes it
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        akt_pkg::OFS_STAT: st_next.rdata = {29'h0, lnk.ka_active, st_reg.clk_done, busy};
        akt_pkg::OFS_MULT: st_next.rdata = {8'h00, st_reg.mult};
        akt_pkg::OFS_DIV: st_next.rdata = {8'h00, st_reg.div};
        akt_pkg::OFS_MISC: st_next.rdata = {31'h0, st_reg.misc};
        akt_pkg::OFS_TS: st_next.rdata = lnk.ts_value;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes land at the end of their data phase
    if (st_reg.dph && st_reg.dwr) begin
      unique case (st_reg.daddr)
        akt_pkg::OFS_CMD: st_next.cmd = hwdata[2:0];
        akt_pkg::OFS_MULT: st_next.mult = hwdata[akt_pkg::TS_VAL_W-1:0];
        akt_pkg::OFS_DIV: st_next.div = hwdata[akt_pkg::TS_VAL_W-1:0];
        akt_pkg::OFS_MISC: st_next.misc = hwdata[0];
        akt_pkg::OFS_STAT: st_next.clk_done = hwdata[1] ? 1'b1 : st_reg.clk_done;
        default: ;
      endcase
    end
    // Command sequencer, at most one link write per cycle
    unique case (st_reg.state)
      ST_IDLE: begin
        if (st_reg.cmd == akt_pkg::CMD_MODE) begin
          st_next.state = ST_KA_OFF;
        end else if (st_reg.cmd == akt_pkg::CMD_CLK) begin
          st_next.we = 1'b1;
          st_next.idx = akt_pkg::DEV_MULT;
          st_next.wdata = {8'h00, st_reg.mult};
          st_next.clk_done = 1'b0;
          st_next.state = ST_WDIV;
        end else if (st_reg.cmd == akt_pkg::CMD_WMISC) begin
          st_next.we = 1'b1;
          st_next.idx = akt_pkg::DEV_MISC;
          st_next.wdata = {31'h0, st_reg.misc};
        end else if (st_reg.cmd == akt_pkg::CMD_KA_ON || st_reg.cmd == akt_pkg::CMD_KA_OFF) begin
          st_next.we = 1'b1;
          st_next.idx = akt_pkg::DEV_VERB;
          st_next.wdata = (st_reg.cmd == akt_pkg::CMD_KA_ON) ? 32'h0000_0080 : 32'h0000_0000;
        end
      end
      // Mode change: keep-alive off first, then two timed waits
      ST_KA_OFF: begin
        st_next.we = 1'b1;
        st_next.idx = akt_pkg::DEV_VERB;
        st_next.wdata = 32'h0000_0000;
        st_next.cnt = 16'(WAIT_CYC - 1);
        st_next.state = ST_WAIT1;
      end
      // First wait; the mode change itself happens away from the link
      ST_WAIT1: begin
        if (st_reg.cnt == 16'h0000) begin
          st_next.cnt = 16'(WAIT_CYC - 1);
          st_next.state = ST_WAIT2;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end
      // Second wait before keep-alive returns
      ST_WAIT2: begin
        if (st_reg.cnt == 16'h0000) begin
          st_next.state = ST_KA_ON;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end
      // Keep-alive back on closes the mode change
      ST_KA_ON: begin
        st_next.we = 1'b1;
        st_next.idx = akt_pkg::DEV_VERB;
        st_next.wdata = 32'h0000_0080;
        st_next.state = ST_IDLE;
      end
      // Clock change after the enable-clearing multiplier write: divisor, then multiplier, then enable
      ST_WDIV: begin
        st_next.we = 1'b1;
        st_next.idx = akt_pkg::DEV_DIV;
        st_next.wdata = {8'h00, st_reg.div};
        st_next.state = ST_WMULT;
      end
      ST_WMULT: begin
        st_next.we = 1'b1;
        st_next.idx = akt_pkg::DEV_MULT;
        st_next.wdata = {8'h00, st_reg.mult};
        st_next.state = ST_TSON;
      end
      // Enable goes out last, with the multiplier unchanged
      ST_TSON: begin
        st_next.we = 1'b1;
        st_next.idx = akt_pkg::DEV_MULT;
        st_next.wdata = {1'b1, 7'h00, st_reg.mult};
        st_next.clk_done = 1'b1;
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  // Zero-wait slave that always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign lnk.cfg_we = st_reg.we;
  assign lnk.cfg_idx = st_reg.idx;
  assign lnk.cfg_wdata = st_reg.wdata;
  // Stream signals pass straight through to the codec
  assign lnk.frame_sync = src_frame_sync;
  assign lnk.stream_id = src_stream_id;
  assign lnk.stream_data = src_data;
  assign lnk.bclk_on = src_bclk_on;
endmodule // akt_ctrl

// file: verif/akt_link_chk.sv
// Purpose: Assertions on the link between controller and codec
// Assumes: Controller built with a wait of four cycles
// Notes: Shadows the settings written over the link
`timescale 1ns/100ps
module akt_link_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link signals
  input wire logic cfg_we,
  input wire logic [1:0] cfg_idx,
  input wire logic [31:0] cfg_wdata,
  input wire logic bclk_on,
  input wire logic ka_active,
  input wire logic [31:0] ts_value
);
  logic verb_reg, misc_reg, ts_en_reg;
  logic [23:0] m_reg, n_reg;
  // Write decodes
  wire wr_m = cfg_we && cfg_idx == akt_pkg::DEV_MULT;
  wire wr_n = cfg_we && cfg_idx == akt_pkg::DEV_DIV;
  wire wr_v = cfg_we && cfg_idx == akt_pkg::DEV_VERB;
  wire run_c = !bclk_on && ka_active && ts_en_reg && m_reg == n_reg && m_reg != 24'h0;
  // Shadow of the codec settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verb_reg <= 1'b0;
      misc_reg <= 1'b0;
      ts_en_reg <= 1'b0;
      m_reg <= 24'h0;
      n_reg <= 24'h0;
    end else begin
      if (wr_v) verb_reg <= cfg_wdata[akt_pkg::KA_BIT];
      if (cfg_we && cfg_idx == akt_pkg::DEV_MISC) misc_reg <= cfg_wdata[akt_pkg::SYNTH_BIT];
      if (wr_m) ts_en_reg <= cfg_wdata[31];
      if (wr_m) m_reg <= cfg_wdata[23:0];
      if (wr_n) n_reg <= cfg_wdata[23:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Tail of the clock change: divisor, multiplier, then enable
  sequence s_div_then_on;
    wr_n ##1 (wr_m && !cfg_wdata[31]) ##1 (wr_m && cfg_wdata[31]);
  endsequence
  a_ka_reset_low: assert property ($rose(hresetn) |-> !ka_active)
    else $error("keep-alive set after reset");
  a_ka_needs_both: assert property (!cfg_we && !$past(cfg_we) |-> ka_active == (verb_reg && misc_reg))
    else $error("keep-alive not verb and synth");
  a_ka_drops: assert property (wr_v && !cfg_wdata[7] |-> ##[1:2] !ka_active)
    else $error("keep-alive stays on");
  a_mode_gap: assert property (wr_v && !cfg_wdata[7] |=> !wr_v [*8])
    else $error("keep-alive set too soon");
  a_clk_order: assert property (wr_m && !cfg_wdata[31] && !$past(cfg_we) |=> s_div_then_on)
    else $error("clock change order wrong");
  a_mult_field: assert property (wr_m && cfg_wdata[31] |-> cfg_wdata[30:0] == {7'h00, m_reg})
    else $error("multiplier field changed");
  a_ts_hold: assert property (bclk_on && $past(bclk_on) |=> $stable(ts_value))
    else $error("timestamp moves with bit clock on");
  a_ts_step: assert property (run_c [*3] |-> ts_value == $past(ts_value) + 32'h1)
    else $error("timestamp step wrong");
endmodule // akt_link_chk

// file: verif/testbench.sv
// Purpose: Self-checking bench for controller and codec joined by the link
// Assumes: Zero wait AHB-Lite slave, wait parameter four
// Notes: Frames note expected output in a queue, a monitor compares
`timescale 1ns/100ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0, sdata = 32'h0, hrdata, out_data, r, t0;
  logic hreadyout, hresp, out_valid, out_silent, fsync = 1'b0, bclk = 1'b1;
  logic [3:0] sid = 4'h0;
  logic [32:0] exq[$];
  int err_total = 0, n_tests = 0, cyc = 0, c0, m, n;
  bit ka_on = 0, link_off = 0;
  akt_link_if lnk ();
  akt_ctrl #(.WAIT_CYC(4)) u_akt_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_frame_sync(fsync), .src_stream_id(sid), .src_data(sdata), .src_bclk_on(bclk),
    .lnk(lnk.ctrl));
  akt_codec u_akt_codec (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.codec),
    .out_valid(out_valid), .out_silent(out_silent), .out_data(out_data));
  akt_link_chk u_akt_link_chk (.hclk(hclk), .hresetn(hresetn), .cfg_we(lnk.cfg_we),
    .cfg_idx(lnk.cfg_idx), .cfg_wdata(lnk.cfg_wdata), .bclk_on(lnk.bclk_on),
    .ka_active(lnk.ka_active), .ts_value(lnk.ts_value));
  // Clock
  initial begin
    forever #20 hclk = ~hclk;
  end
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic cmd(input logic [2:0] c);
    logic [31:0] v;
    xfer(1, akt_pkg::OFS_CMD, {29'h0, c}, v);
    do xfer(0, akt_pkg::OFS_STAT, 32'h0, v); while (v[0] !== 1'b0);
  endtask
  // One frame with its expected codec output
  task automatic frame(input logic [3:0] id);
    logic [31:0] d;
    d = $urandom;
    fsync <= 1'b1;
    sid <= id;
    sdata <= d;
    if (id != 4'h0) exq.push_back({1'b0, d});
    else if (ka_on) exq.push_back({1'b1, akt_pkg::SILENT_WORD});
    @(posedge hclk);
    fsync <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // Monitor and timeout, on the falling edge where outputs are settled
  always @(negedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end else if (hresetn && out_valid === 1'b1 && !link_off) begin
      if (exq.size() == 0) check(1'b1, 1'b0);
      else check({out_silent, out_data}, exq.pop_front());
    end
  end
  // Main sequence
  initial begin
    void'($urandom(36730));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, akt_pkg::OFS_STAT, 32'h0, r);
    check(r[2], 1'b0);
    frame(4'h0);
    frame(4'h3);
    cmd(akt_pkg::CMD_KA_ON);
    xfer(0, akt_pkg::OFS_STAT, 32'h0, r);
    check(r[2], 1'b0);
    xfer(1, akt_pkg::OFS_MISC, 32'h1, r);
    cmd(akt_pkg::CMD_WMISC);
    xfer(0, akt_pkg::OFS_STAT, 32'h0, r);
    check(r[2], 1'b1);
    ka_on = 1;
    repeat (12) frame(4'($urandom % 3));
    cmd(akt_pkg::CMD_MODE);
    xfer(0, akt_pkg::OFS_STAT, 32'h0, r);
    check(r[2], 1'b1);
    frame(4'h0);
    for (int k = 0; k < 2; k++) begin
      m = 1 + $urandom % 7;
      n = (k == 0) ? m : m + 1 + $urandom % 8;
      xfer(1, akt_pkg::OFS_MULT, m, r);
      xfer(1, akt_pkg::OFS_DIV, n, r);
      xfer(0, akt_pkg::OFS_MULT, 32'h0, r);
      check(r, m);
      xfer(0, akt_pkg::OFS_DIV, 32'h0, r);
      check(r, n);
      cmd(akt_pkg::CMD_CLK);
      xfer(0, akt_pkg::OFS_STAT, 32'h0, r);
      check(r[2:1], 2'b11);
      link_off = 1;
      bclk <= 1'b0;
      repeat (3) @(posedge hclk);
      xfer(0, akt_pkg::OFS_TS, 32'h0, t0);
      c0 = cyc;
      repeat (40) begin
        @(negedge hclk);
        check({out_valid, out_silent, out_data}, {2'b11, akt_pkg::SILENT_WORD});
      end
      @(posedge hclk);
      xfer(0, akt_pkg::OFS_TS, 32'h0, r);
      check((r - t0) * n + n > (cyc - c0) * m && (r - t0) * n < (cyc - c0) * m + n, 1);
      bclk <= 1'b1;
      repeat (3) @(posedge hclk);
      link_off = 0;
    end
    cmd(akt_pkg::CMD_KA_OFF);
    ka_on = 0;
    frame(4'h0);
    frame(4'h5);
    xfer(1, 8'h1C, 32'hFFFF_FFFF, r);
    xfer(0, 8'h1C, 32'h0, r);
    check(r, 32'h0);
    check(exq.size(), 0);
    stop_test();
  end
endmodule // testbench
